// ### rtl/lrac_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lrac_regs.svh"

module lrac_top #(
    parameter int SEC_CYCLES = `LRAC_SEC_NS / `LRAC_CLK_NS
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic [9:0]             reg_addr_i,
    input  wire logic                   reg_wr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_rd_i,
    input  wire logic                   memory_cleared_i,
    input  wire logic                   taf_clear_i,
    input  wire logic                   conv_valid_i,
    input  wire logic signed [9:0]      conv_code_i,
    output logic [7:0]                  reg_rdata_o,
    output logic                        timer_alarm_flag_o,
    output logic                        alarm_pulse_o,
    output logic                        cond_search_o,
    output lrac_pkg::lrac_mission_type  mission_state_o,
    output logic                        mission_start_o,
    output logic                        mission_end_o,
    output logic [7:0]                  sample_interval_o,
    output logic [7:0]                  low_thresh_o,
    output logic [7:0]                  high_thresh_o,
    output logic                        clear_arm_o,
    output logic                        log_wrap_o,
    output logic                        low_search_o,
    output logic                        high_search_o
);
    import lrac_pkg::*;

    ////////////////////////////////////////////////////////////////////
    localparam lrac_state_type RST = '{
        div: 24'h0, sec: `LRAC_RST_ZERO, min: `LRAC_RST_ZERO,
        hr: `LRAC_RST_ZERO, dow: `LRAC_RST_ONE, date: `LRAC_RST_ONE,
        mon: `LRAC_RST_ONE, yr: `LRAC_RST_ZERO, al: 32'h0,
        tlo: `LRAC_RST_ZERO, thi: `LRAC_RST_ZERO, rate: `LRAC_RST_ZERO,
        ctrl: `LRAC_RST_ZERO, temp: `LRAC_RST_ZERO, rdata: `LRAC_RST_ZERO,
        timer_alarm_flag: 1'b0, chk: 1'b0, alarm_p: 1'b0, start_p: 1'b0, end_p: 1'b0,
        mission: LRAC_IDLE};

    lrac_state_type s_ff;
    lrac_state_type nxt_s;
    logic           tick;
    logic           hr_step;
    logic           day_carry;
    logic           match;
    logic           wr_rate;
    logic           wr_ctrl;
    logic           start_ok;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] >= `LRAC_BCD_9) ? {v[7:4] + 4'h1, 4'h0}
                                          : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Year 00 counts as leap, no century exception
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
    endfunction

    function automatic logic [5:0] month_days(input logic [4:0] m,
                                              input logic       leap);
        if (m == `LRAC_M_FEB) begin
            month_days = leap ? `LRAC_D29 : `LRAC_D28;
        end else if (m == `LRAC_M_APR || m == `LRAC_M_JUN ||
                     m == `LRAC_M_SEP || m == `LRAC_M_NOV) begin
            month_days = `LRAC_D30;
        end else begin
            month_days = `LRAC_D31;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Halted oscillator freezes the whole calendar
    assign tick = !s_ff.ctrl[`LRAC_C_OSC] && (s_ff.div == 24'(SEC_CYCLES - 1));
    // Unrelated host writes must not swallow the day carry
    assign hr_step = tick && s_ff.sec[6:0] == `LRAC_B59
                     && s_ff.min[6:0] == `LRAC_B59;
    // Day rolls over only at the 11 PM to 12 AM step
    assign day_carry = hr_step && (s_ff.hr[`LRAC_HR_FMT]
                       ? (s_ff.hr[4:0] == `LRAC_H11 && s_ff.hr[`LRAC_HR_PM])
                       : (s_ff.hr[5:0] == `LRAC_H23));
    // Set mask bit drops the field from the compare
    assign match = (s_ff.al[0][`LRAC_MASK] || s_ff.al[0][6:0] == s_ff.sec[6:0])
                && (s_ff.al[1][`LRAC_MASK] || s_ff.al[1][6:0] == s_ff.min[6:0])
                && (s_ff.al[2][`LRAC_MASK] || s_ff.al[2][6:0] == s_ff.hr[6:0])
                && (s_ff.al[3][`LRAC_MASK] || s_ff.al[3][2:0] == s_ff.dow[2:0]);
    assign wr_rate = reg_wr_i && reg_addr_i == `LRAC_A_RATE;
    assign wr_ctrl = reg_wr_i && reg_addr_i == `LRAC_A_CTRL;
    // Start needs cleared memory and inhibit low
    assign start_ok = reg_wdata_i != `LRAC_RST_ZERO && memory_cleared_i
                      && !s_ff.ctrl[`LRAC_C_INH];

    always_comb begin
        logic [7:0] h12;
        logic [7:0] h24;
        logic [7:0] mi;
        logic [5:0] lim;
        h12 = bcd_inc({3'h0, s_ff.hr[4:0]});
        h24 = bcd_inc({2'h0, s_ff.hr[5:0]});
        mi = bcd_inc({3'h0, s_ff.mon[4:0]});
        lim = month_days(s_ff.mon[4:0], is_leap(s_ff.yr));
        nxt_s = s_ff;
        nxt_s.alarm_p = 1'b0;
        nxt_s.start_p = 1'b0;
        nxt_s.end_p = 1'b0;
        nxt_s.chk = tick;
        if (!s_ff.ctrl[`LRAC_C_OSC]) begin
            nxt_s.div = tick ? 24'h0 : s_ff.div + 24'h1;
        end
        // BCD carry chain on each second
        if (tick) begin
            if (s_ff.sec[6:0] == `LRAC_B59) begin
                nxt_s.sec = `LRAC_RST_ZERO;
                if (s_ff.min[6:0] == `LRAC_B59) begin
                    nxt_s.min = `LRAC_RST_ZERO;
                    if (s_ff.hr[`LRAC_HR_FMT]) begin
                        if (s_ff.hr[4:0] == `LRAC_H12) begin
                            nxt_s.hr = {s_ff.hr[7:5], `LRAC_H01};
                        end else if (s_ff.hr[4:0] == `LRAC_H11) begin
                            nxt_s.hr = {s_ff.hr[7:6], ~s_ff.hr[5], `LRAC_H12};
                        end else begin
                            nxt_s.hr = {s_ff.hr[7:5], h12[4:0]};
                        end
                    end else if (s_ff.hr[5:0] == `LRAC_H23) begin
                        // Bit 5 is the twenty-hours digit here
                        nxt_s.hr = {s_ff.hr[7:6], 6'h0};
                    end else begin
                        nxt_s.hr = {s_ff.hr[7:6], h24[5:0]};
                    end
                end else begin
                    nxt_s.min = bcd_inc(s_ff.min);
                end
            end else begin
                nxt_s.sec = bcd_inc(s_ff.sec);
            end
        end
        if (day_carry) begin
            if (s_ff.dow[2:0] == `LRAC_DOW_MAX) begin
                nxt_s.dow = {5'h0, `LRAC_DOW_MIN};
            end else begin
                nxt_s.dow = s_ff.dow + 8'h1;
            end
            if (s_ff.date[5:0] == lim) begin
                nxt_s.date = {2'h0, `LRAC_D01};
                if (s_ff.mon[4:0] == `LRAC_M_DEC) begin
                    nxt_s.mon = {s_ff.mon[7:5], `LRAC_M_JAN};
                    if (s_ff.yr == `LRAC_Y99) begin
                        nxt_s.yr = `LRAC_RST_ZERO;
                        nxt_s.mon[`LRAC_CENTURY_FLAG] = ~s_ff.mon[`LRAC_CENTURY_FLAG];
                    end else begin
                        nxt_s.yr = bcd_inc(s_ff.yr);
                    end
                end else begin
                    nxt_s.mon = {s_ff.mon[7:5], mi[4:0]};
                end
            end else begin
                nxt_s.date = bcd_inc(s_ff.date);
            end
        end
        if (taf_clear_i) begin
            nxt_s.timer_alarm_flag = 1'b0;
        end
        // Compared one cycle after the update
        if (s_ff.chk && match) begin
            nxt_s.alarm_p = 1'b1;
            nxt_s.timer_alarm_flag = 1'b1;
        end
        if (conv_valid_i) begin
            if (conv_code_i < 10'sh0) begin
                nxt_s.temp = `LRAC_T_MIN;
            end else if (conv_code_i > $signed({2'h0, `LRAC_T_MAX})) begin
                nxt_s.temp = `LRAC_T_MAX;
            end else begin
                nxt_s.temp = conv_code_i[7:0];
            end
        end
        // Host writes take priority over counting
        // Fixed zero bits masked on write
        if (reg_wr_i) begin
            case (reg_addr_i)
                `LRAC_A_SEC: begin
                    nxt_s.sec = reg_wdata_i & `LRAC_WM_SEC;
                end
                `LRAC_A_MIN: begin
                    nxt_s.min = reg_wdata_i & `LRAC_WM_SEC;
                end
                `LRAC_A_HR: begin
                    nxt_s.hr = reg_wdata_i & `LRAC_WM_HR;
                end
                `LRAC_A_DOW: begin
                    nxt_s.dow = reg_wdata_i & `LRAC_WM_DOW;
                end
                `LRAC_A_DATE: begin
                    nxt_s.date = reg_wdata_i & `LRAC_WM_DATE;
                end
                `LRAC_A_MON: begin
                    nxt_s.mon = reg_wdata_i & `LRAC_WM_MON;
                end
                `LRAC_A_YR: begin
                    nxt_s.yr = reg_wdata_i;
                end
                `LRAC_A_ALS: begin
                    nxt_s.al[0] = reg_wdata_i;
                end
                `LRAC_A_ALM: begin
                    nxt_s.al[1] = reg_wdata_i;
                end
                `LRAC_A_ALH: begin
                    nxt_s.al[2] = reg_wdata_i;
                end
                `LRAC_A_ALD: begin
                    nxt_s.al[3] = reg_wdata_i & `LRAC_WM_ALD;
                end
                `LRAC_A_TLO: begin
                    nxt_s.tlo = reg_wdata_i;
                end
                `LRAC_A_THI: begin
                    nxt_s.thi = reg_wdata_i;
                end
                `LRAC_A_RATE: begin
                    nxt_s.rate = reg_wdata_i;
                end
                `LRAC_A_CTRL: begin
                    // Bit 5 never stores a one
                    nxt_s.ctrl = reg_wdata_i & `LRAC_WM_CTRL;
                end
                default: begin
                end
            endcase
        end
        unique case (s_ff.mission)
            LRAC_IDLE: begin
                if (wr_rate && start_ok) begin
                    nxt_s.mission = LRAC_MISSION;
                    nxt_s.start_p = 1'b1;
                end
            end
            LRAC_MISSION: begin
                if (wr_ctrl) begin
                    nxt_s.mission = LRAC_IDLE;
                    nxt_s.end_p = 1'b1;
                end
            end
        endcase
        // Read data lands one cycle after the strobe
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LRAC_A_SEC:  nxt_s.rdata = s_ff.sec;
                `LRAC_A_MIN:  nxt_s.rdata = s_ff.min;
                `LRAC_A_HR:   nxt_s.rdata = s_ff.hr;
                `LRAC_A_DOW:  nxt_s.rdata = s_ff.dow;
                `LRAC_A_DATE: nxt_s.rdata = s_ff.date;
                `LRAC_A_MON:  nxt_s.rdata = s_ff.mon;
                `LRAC_A_YR:   nxt_s.rdata = s_ff.yr;
                `LRAC_A_ALS:  nxt_s.rdata = s_ff.al[0];
                `LRAC_A_ALM:  nxt_s.rdata = s_ff.al[1];
                `LRAC_A_ALH:  nxt_s.rdata = s_ff.al[2];
                `LRAC_A_ALD:  nxt_s.rdata = s_ff.al[3];
                `LRAC_A_TLO:  nxt_s.rdata = s_ff.tlo;
                `LRAC_A_THI:  nxt_s.rdata = s_ff.thi;
                `LRAC_A_RATE: nxt_s.rdata = s_ff.rate;
                `LRAC_A_CTRL: nxt_s.rdata = s_ff.ctrl;
                // Same code format as logged samples
                `LRAC_A_TEMP: nxt_s.rdata = s_ff.temp;
                default:      nxt_s.rdata = `LRAC_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_ff <= RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign reg_rdata_o = s_ff.rdata;
    assign timer_alarm_flag_o = s_ff.timer_alarm_flag;
    assign alarm_pulse_o = s_ff.alarm_p;
    // Timer search follows the alarm flag
    assign cond_search_o = s_ff.ctrl[`LRAC_C_TMR] && s_ff.timer_alarm_flag;
    assign mission_state_o = s_ff.mission;
    assign mission_start_o = s_ff.start_p;
    assign mission_end_o = s_ff.end_p;
    // Interval in minutes for the logger
    assign sample_interval_o = s_ff.rate;
    assign low_thresh_o = s_ff.tlo;
    assign high_thresh_o = s_ff.thi;
    assign clear_arm_o = s_ff.ctrl[`LRAC_C_CLR];
    assign log_wrap_o = s_ff.ctrl[`LRAC_C_WRAP];
    assign low_search_o = s_ff.ctrl[`LRAC_C_LOW];
    assign high_search_o = s_ff.ctrl[`LRAC_C_HIGH];

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    hour_fmt_a: assert property (
        hr_step && !reg_wr_i && !s_ff.hr[`LRAC_HR_FMT] && s_ff.hr[5:0] == `LRAC_H23
        |=> s_ff.hr[6:0] == 7'h0) else $error("24h wrap wrong");
    pm_toggle_a: assert property (
        hr_step && !reg_wr_i && s_ff.hr[`LRAC_HR_FMT] && s_ff.hr[4:0] == `LRAC_H11
        |=> s_ff.hr[`LRAC_HR_PM] != $past(s_ff.hr[`LRAC_HR_PM])
            && s_ff.hr[4:0] == `LRAC_H12) else $error("PM not toggled");
    twelve_one_a: assert property (
        hr_step && !reg_wr_i && s_ff.hr[`LRAC_HR_FMT] && s_ff.hr[4:0] == `LRAC_H12
        |=> s_ff.hr[4:0] == `LRAC_H01) else $error("12 to 1 failed");
    dow_wrap_a: assert property (
        day_carry && !reg_wr_i && s_ff.dow[2:0] == `LRAC_DOW_MAX
        |=> s_ff.dow[2:0] == `LRAC_DOW_MIN) else $error("weekday wrap");
    leap_day_a: assert property (
        day_carry && !reg_wr_i && s_ff.mon[4:0] == `LRAC_M_FEB
        && s_ff.date[5:0] == `LRAC_D28
        |=> s_ff.date[5:0] == ($past(is_leap(s_ff.yr)) ? `LRAC_D29 : `LRAC_D01))
        else $error("leap day wrong");
    century_a: assert property (
        day_carry && !reg_wr_i && s_ff.mon[4:0] == `LRAC_M_DEC
        && s_ff.date[5:0] == `LRAC_D31
        && s_ff.yr == `LRAC_Y99
        |=> s_ff.mon[`LRAC_CENTURY_FLAG] != $past(s_ff.mon[`LRAC_CENTURY_FLAG])
            && s_ff.yr == `LRAC_RST_ZERO) else $error("century not toggled");
    every_sec_a: assert property (
        tick && !reg_wr_i && s_ff.al[0][7] && s_ff.al[1][7] && s_ff.al[2][7]
        && s_ff.al[3][7] |=> ##1 alarm_pulse_o) else $error("no per-second alarm");
    weekly_miss_a: assert property (
        s_ff.chk && s_ff.al[3][7:0] != {5'h0, s_ff.dow[2:0]}
        && !s_ff.al[3][`LRAC_MASK] |=> !alarm_pulse_o) else $error("bad weekday hit");
    taf_set_a: assert property (
        alarm_pulse_o |-> timer_alarm_flag_o ##1 (timer_alarm_flag_o || $past(taf_clear_i)))
        else $error("alarm flag missing");
    search_a: assert property (
        alarm_pulse_o && s_ff.ctrl[`LRAC_C_TMR] |-> cond_search_o)
        else $error("search not answered");
    clamp_a: assert property (
        conv_valid_i && conv_code_i < 10'sh0 |=> s_ff.temp == `LRAC_T_MIN)
        else $error("low clamp");
    start_a: assert property (
        wr_rate && start_ok && mission_state_o == LRAC_IDLE
        |=> mission_start_o && mission_state_o == LRAC_MISSION) else $error("no start");
    ctrl_end_a: assert property (
        wr_ctrl && mission_state_o == LRAC_MISSION
        |=> mission_end_o && mission_state_o == LRAC_IDLE) else $error("no end");
    bit5_a: assert property (
        !s_ff.ctrl[`LRAC_C_ZERO] && s_ff.dow[7:3] == 5'h0) else $error("zero bit set");
endmodule
`default_nettype wire

// ### rtl/lrac_regs.svh
`ifndef LRAC_REGS_SVH
`define LRAC_REGS_SVH
// Register page addresses
`define LRAC_A_SEC   10'h200
`define LRAC_A_MIN   10'h201
`define LRAC_A_HR    10'h202
`define LRAC_A_DOW   10'h203
`define LRAC_A_DATE  10'h204
`define LRAC_A_MON   10'h205
`define LRAC_A_YR    10'h206
`define LRAC_A_ALS   10'h207
`define LRAC_A_ALM   10'h208
`define LRAC_A_ALH   10'h209
`define LRAC_A_ALD   10'h20a
`define LRAC_A_TLO   10'h20b
`define LRAC_A_THI   10'h20c
`define LRAC_A_RATE  10'h20d
`define LRAC_A_CTRL  10'h20e
`define LRAC_A_TEMP  10'h211
// Writable bits; the rest read as zero
`define LRAC_WM_SEC  8'h7f
`define LRAC_WM_HR   8'h7f
`define LRAC_WM_DOW  8'h07
`define LRAC_WM_DATE 8'h3f
`define LRAC_WM_MON  8'h9f
`define LRAC_WM_ALD  8'h87
`define LRAC_WM_CTRL 8'hdf
// Bit positions
`define LRAC_HR_FMT  6
`define LRAC_HR_PM   5
`define LRAC_CENTURY_FLAG    7
`define LRAC_MASK    7
`define LRAC_C_OSC   7
`define LRAC_C_CLR   6
`define LRAC_C_ZERO  5
`define LRAC_C_INH   4
`define LRAC_C_WRAP  3
`define LRAC_C_LOW   2
`define LRAC_C_HIGH  1
`define LRAC_C_TMR   0
// Reset values
`define LRAC_RST_ZERO 8'h00
`define LRAC_RST_ONE  8'h01
// Calendar limits, BCD
`define LRAC_BCD_9   4'h9
`define LRAC_B59     7'h59
`define LRAC_H23     6'h23
`define LRAC_H12     5'h12
`define LRAC_H11     5'h11
`define LRAC_H01     5'h01
`define LRAC_DOW_MAX 3'h7
`define LRAC_DOW_MIN 3'h1
`define LRAC_M_FEB   5'h02
`define LRAC_M_APR   5'h04
`define LRAC_M_JUN   5'h06
`define LRAC_M_SEP   5'h09
`define LRAC_M_NOV   5'h11
`define LRAC_M_DEC   5'h12
`define LRAC_M_JAN   5'h01
`define LRAC_D28     6'h28
`define LRAC_D29     6'h29
`define LRAC_D30     6'h30
`define LRAC_D31     6'h31
`define LRAC_D01     6'h01
`define LRAC_Y99     8'h99
// Temperature code limits
`define LRAC_T_MIN   8'h00
`define LRAC_T_MAX   8'hfa
// Timing
`define LRAC_CLK_NS  100
`define LRAC_SEC_NS  1000000000
`endif

// ### rtl/lrac_pkg.sv
package lrac_pkg;
    typedef enum logic {
        LRAC_IDLE,
        LRAC_MISSION
    } lrac_mission_type;

    typedef struct packed {
        logic [23:0]      div;
        logic [7:0]       sec;
        logic [7:0]       min;
        logic [7:0]       hr;
        logic [7:0]       dow;
        logic [7:0]       date;
        logic [7:0]       mon;
        logic [7:0]       yr;
        logic [3:0][7:0]  al;
        logic [7:0]       tlo;
        logic [7:0]       thi;
        logic [7:0]       rate;
        logic [7:0]       ctrl;
        logic [7:0]       temp;
        logic [7:0]       rdata;
        logic             timer_alarm_flag;
        logic             chk;
        logic             alarm_p;
        logic             start_p;
        logic             end_p;
        lrac_mission_type mission;
    } lrac_state_type;
endpackage

// ### verification/lrac_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lrac_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var logic  [9:0] addr_o,
    output var logic        wr_o,
    output var logic        rd_o,
    output var logic  [7:0] wdata_o
);
    initial {addr_o, wr_o, rd_o, wdata_o} = '0;
    // Strobe held one edge, then data line shows junk
    task automatic acc(input logic [9:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk_i);
        #10 {addr_o, wr_o, rd_o, wdata_o} = {a, w, !w, d};
        @(posedge clk_i);
        #10 {wr_o, rd_o, wdata_o} = {2'b00, ~d};
        q = rdata_i;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_logger_rtc_alarm_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "lrac_regs.svh"
module tb_logger_rtc_alarm_config;
    import lrac_pkg::*;
    logic clk_sys_i = 0, rst_i = 1, mc = 0, tc = 0, cv = 0, timer_alarm_flag, ap, cs, ms, me, wrap, hs, w, r;
    logic signed [9:0] code = '0;
    logic [9:0] a;
    logic [7:0] wd, rd, q, rate, lt;
    lrac_mission_type st;
    int failures = 0, n_checks = 0, s, m, h, dw, dt, mo, y, ct, i;
    int tbl [6][9] = '{'{59,59,23,7,28,2,4,0,0}, '{59,59,23,3,28,2,5,0,0},
        '{59,59,23,1,31,12,99,1,0}, '{59,59,23,2,28,2,0,1,1},
        '{59,59,11,4,30,4,7,1,1}, '{59,59,12,5,15,6,8,1,1}};
    int tv [6] = '{-1, 0, 250, 251, -80, 319};
    always #50 clk_sys_i = ~clk_sys_i;
    lrac_top #(.SEC_CYCLES(8)) lrac_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(a), .reg_wr_i(w), .reg_wdata_i(wd), .reg_rd_i(r), .memory_cleared_i(mc),
        .taf_clear_i(tc), .conv_valid_i(cv), .conv_code_i(code), .reg_rdata_o(rd),
        .timer_alarm_flag_o(timer_alarm_flag), .alarm_pulse_o(ap), .cond_search_o(cs),
        .mission_state_o(st), .mission_start_o(ms), .mission_end_o(me),
        .sample_interval_o(rate), .low_thresh_o(lt), .high_thresh_o(), .clear_arm_o(),
        .log_wrap_o(wrap), .low_search_o(), .high_search_o(hs));
    lrac_host_model lrac_host_model_inst (.clk_i(clk_sys_i), .rdata_i(rd), .addr_o(a),
        .wr_o(w), .rd_o(r), .wdata_o(wd));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [9:0] ad, input logic [7:0] d);
        lrac_host_model_inst.acc(ad, 1'b1, d, q);
    endtask
    task automatic rc(input logic [9:0] ad, input logic [7:0] e);
        lrac_host_model_inst.acc(ad, 1'b0, 8'h00, q);
        chk(e, q);
    endtask
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    function automatic logic [7:0] hrc(input int md);
        return md ? 8'h40 | (h >= 12 ? 8'h20 : 8'h00) | bcd((h + 11) % 12 + 1) : bcd(h);
    endfunction
    function automatic int mdays();
        return mo == 2 ? (y % 4 == 0 ? 29 : 28) : (mo inside {4, 6, 9, 11} ? 30 : 31);
    endfunction
    task automatic tick();
        s = (s + 1) % 60;
        if (s == 0) m = (m + 1) % 60;
        if (s + m == 0) h = (h + 1) % 24;
        if (s + m + h == 0) dw = dw % 7 + 1;
        if (s + m + h == 0) dt = dt % mdays() + 1;
        if (s + m + h == 0 && dt == 1) mo = mo % 12 + 1;
        if (s + m + h == 0 && dt == 1 && mo == 1) y = (y + 1) % 100;
        if (s + m + h + y == 0 && dt == 1 && mo == 1) ct ^= 1;
    endtask
    // Masked alarm fields get a value no field can hold
    function automatic logic [7:0] al(input logic mk, input logic [7:0] v);
        return mk ? 8'hff : {1'b0, v[6:0]};
    endfunction
    task automatic cal(input int md, input int k);
        int n;
        wr(`LRAC_A_CTRL, 8'h81);
        wr(`LRAC_A_SEC, bcd(s));
        wr(`LRAC_A_MIN, bcd(m));
        wr(`LRAC_A_HR, hrc(md));
        wr(`LRAC_A_DOW, bcd(dw));
        wr(`LRAC_A_DATE, bcd(dt));
        wr(`LRAC_A_MON, bcd(mo) | (ct ? 8'h80 : 8'h00));
        wr(`LRAC_A_YR, bcd(y));
        tick();
        wr(`LRAC_A_ALS, al(k < 1, bcd(s)));
        wr(`LRAC_A_ALM, al(k < 2, bcd(m)));
        wr(`LRAC_A_ALH, al(k < 3, hrc(md)));
        wr(`LRAC_A_ALD, al(k < 4, bcd(dw)));
        wr(`LRAC_A_CTRL, 8'h01);
        n = 0;
        while (ap !== 1'b1 && n < 40) begin
            @(posedge clk_sys_i);
            #10 n++;
        end
        chk(8'h01, 8'(ap));
        if (n == 40) stop_test();
        wr(`LRAC_A_CTRL, 8'h81);
        chk(8'h01, 8'(timer_alarm_flag));
        chk(8'h01, 8'(cs));
        rc(`LRAC_A_SEC, bcd(s));
        rc(`LRAC_A_MIN, bcd(m));
        rc(`LRAC_A_HR, hrc(md));
        rc(`LRAC_A_DOW, bcd(dw));
        rc(`LRAC_A_DATE, bcd(dt));
        rc(`LRAC_A_MON, bcd(mo) | (ct ? 8'h80 : 8'h00));
        rc(`LRAC_A_YR, bcd(y));
        @(posedge clk_sys_i);
        #10 tc = 1;
        @(posedge clk_sys_i);
        #10 tc = 0;
        chk(8'h00, 8'(timer_alarm_flag));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(44));
        repeat (2) @(posedge clk_sys_i);
        #10 rst_i = 0;
        rc(`LRAC_A_DOW, 8'h01);
        rc(10'h20f, 8'h00);
        wr(`LRAC_A_CTRL, 8'hff);
        rc(`LRAC_A_CTRL, 8'hdf);
        wr(`LRAC_A_DOW, 8'hff);
        rc(`LRAC_A_DOW, 8'h07);
        $display("register test done");
        for (i = 0; i < 10; i++) begin
            {s, m, h, dw, dt, mo} = {32'd59, 32'd59, 32'd0, 32'd1, 32'd1, 32'd1};
            if (i < 6) begin
                {s, m, h, dw, dt, mo, y, ct} = {tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3],
                    tbl[i][4], tbl[i][5], tbl[i][6], tbl[i][7]};
                cal(tbl[i][8], i % 5);
            end else begin
                {s, m, h, dw} = {$urandom % 60, $urandom % 60, $urandom % 24, $urandom % 7 + 1};
                {dt, mo, y, ct} = {$urandom % 28 + 1, $urandom % 12 + 1, $urandom % 100, 32'd1};
                cal($urandom % 2, $urandom % 5);
            end
        end
        $display("calendar test done");
        for (i = 0; i < 12; i++) begin
            @(posedge clk_sys_i);
            #10 code = 10'(i < 6 ? tv[i] : int'($urandom % 400) - 80);
            cv = 1;
            @(posedge clk_sys_i);
            #10 cv = 0;
            rc(`LRAC_A_TEMP, 8'(code < 0 ? 0 : code > 250 ? 250 : code));
        end
        wr(`LRAC_A_TLO, 8'(2 * 23 + 80));
        rc(`LRAC_A_TLO, 8'h7e);
        chk(8'h7e, lt);
        $display("temperature test done");
        mc = 1;
        wr(`LRAC_A_CTRL, 8'h90);
        wr(`LRAC_A_RATE, 8'h05);
        chk(8'(LRAC_IDLE), 8'(st));
        wr(`LRAC_A_CTRL, 8'h80);
        wr(`LRAC_A_RATE, 8'h00);
        chk(8'(LRAC_IDLE), 8'(st));
        mc = 0;
        wr(`LRAC_A_RATE, 8'h07);
        chk(8'(LRAC_IDLE), 8'(st));
        mc = 1;
        wr(`LRAC_A_RATE, 8'hff);
        chk(8'h01, 8'(ms));
        chk(8'(LRAC_MISSION), 8'(st));
        chk(8'hff, rate);
        wr(`LRAC_A_CTRL, 8'h8a);
        chk(8'h01, 8'(me));
        chk(8'(LRAC_IDLE), 8'(st));
        chk(8'h03, {6'h00, wrap, hs});
        $display("mission test done");
        stop_test();
    end
endmodule
`default_nettype wire
